// ### common/sab_defines.vh
// Constants for the SMBus address, timeout and alert block
`ifndef SAB_DEFINES_VH
`define SAB_DEFINES_VH
// Clock rate and bus timeout
`define SAB_CLK_HZ          100000000
`define SAB_TLOW_TIMEOUT_MS 25
`define SAB_TIMEOUT_CYC     22'd2500000
`define SAB_TIMEOUT_W       22
// Command codes
`define SAB_CMD_CLEAR_FAULT 8'h03
`define SAB_CMD_ALERT_MASK  8'hd8
// Alert mask reset value
`define SAB_MASK_RST        16'h0000
// Alert response address, 7 bit
`define SAB_ARA_ADDR        7'h0c
// Strap level codes
`define SAB_STRAP_OPEN      2'h0
`define SAB_STRAP_LOW       2'h1
`define SAB_STRAP_HIGH      2'h2
// Address groups of the strap decode
`define SAB_GRP0_BASE       7'h40
`define SAB_GRP1_BASE       7'h10
`define SAB_GRP2_BASE       7'h50
`define SAB_GRP1_IDX        5'h08
`define SAB_GRP2_IDX        5'h10
// Byte returned for an unmapped read
`define SAB_IDLE_BYTE       8'hff
`endif

// ### tb/sab_host_model.sv
// Behavioural SMBus master driving the bus clock and data wires
`default_nettype none
module sab_host_model (
    output var logic scl,
    output var logic sda_low,
    input wire logic sda
);
    timeunit 1ns / 100ps;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Bit cell of 125 ns, 75 ns low, no clock extension
    task automatic bit_x(input logic b, output logic r);
        scl = 1'b0;
        #25 sda_low = !b;
        #50 scl = 1'b1;
        #25 r = sda;
        #25;
    endtask
    // Start when p is 0, stop when p is 1
    task automatic cond_c(input logic p);
        scl = 1'b0;
        #25 sda_low = p;
        #50 scl = 1'b1;
        #50 sda_low = !p;
        #50;
    endtask
    task automatic low_c();
        scl = 1'b0;
    endtask
    // Byte MSB first, then ack cell a
    task automatic byte_x(input logic [7:0] d, input logic a, output logic [7:0] q,
                          output logic k);
        for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
        bit_x(a, k);
    endtask
endmodule
`default_nettype wire

// ### tb/sab_smbus_checker.sv
// Assertion checker bound to the SMBus target block
`default_nettype none
module sab_smbus_checker #(
    parameter [21:0] TIMEOUT_CYC = 22'd2500000
) (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    input wire logic        scl_i,
    input wire logic        scl_oe_n,
    input wire logic        sda_oe_n,
    input wire logic        alert_o,
    input wire logic        alert_oe_n,
    input wire logic        enable_in,
    input wire logic        vdd_ok,
    input wire logic        vref_ok,
    input wire logic [15:0] fault_in,
    input wire logic [6:0]  dev_addr_q,
    input wire logic        addr_valid_q,
    input wire logic [15:0] alert_mask_q,
    input wire logic [15:0] auto_mask_q
);
    timeunit 1ns / 100ps;
    logic [22:0] low_cnt_q;
    wire         unmasked = |(fault_in & ~alert_mask_q & ~auto_mask_q);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Cycles of bus clock held low
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) low_cnt_q <= 23'h0;
        else if (scl_i) low_cnt_q <= 23'h0;
        else if (clk_en && !(&low_cnt_q)) low_cnt_q <= low_cnt_q + 23'h1;
    end
    pins_fixed_a: assert property (scl_oe_n && !alert_o)
        else $error("clock pin driven or alert level wrong");
    alert_on_a: assert property (clk_en && unmasked |=> !alert_oe_n)
        else $error("unmasked fault without alert");
    alert_off_a: assert property (clk_en && !unmasked |=> alert_oe_n)
        else $error("alert with every fault masked");
    auto_set_a: assert property ($changed(auto_mask_q) && |auto_mask_q |-> !$past(alert_oe_n))
        else $error("automatic mask set without alert");
    auto_keep_a: assert property (|($past(auto_mask_q) & ~auto_mask_q) |-> auto_mask_q == 0)
        else $error("automatic mask partly cleared");
    latch_ready_a: assert property ($rose(addr_valid_q) |->
        $past(enable_in, 2) && $past(vdd_ok, 2) && $past(vref_ok, 2))
        else $error("address latched before ready");
    addr_hold_a: assert property (addr_valid_q && $past(addr_valid_q) |-> $stable(dev_addr_q))
        else $error("address moved while latched");
    addr_range_a: assert property (addr_valid_q |->
        dev_addr_q inside {[7'h40:7'h47], [7'h10:7'h17], [7'h50:7'h5a]})
        else $error("address outside decode groups");
    rail_drop_a: assert property ((clk_en && !vdd_ok) [*8] |-> !addr_valid_q)
        else $error("address valid without supply");
    timeout_rel_a: assert property (low_cnt_q > TIMEOUT_CYC + 8 |-> sda_oe_n)
        else $error("data held after clock low timeout");
    cover property ($rose(addr_valid_q));
    cover property ($rose(|auto_mask_q));
    cover property (low_cnt_q == TIMEOUT_CYC + 8);
endmodule
bind sab_smbus_target sab_smbus_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_sab_smbus_checker (
    .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .scl_i(scl_i), .scl_oe_n(scl_oe_n),
    .sda_oe_n(sda_oe_n), .alert_o(alert_o), .alert_oe_n(alert_oe_n), .enable_in(enable_in),
    .vdd_ok(vdd_ok), .vref_ok(vref_ok), .fault_in(fault_in), .dev_addr_q(dev_addr_q),
    .addr_valid_q(addr_valid_q), .alert_mask_q(alert_mask_q), .auto_mask_q(auto_mask_q));
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the SMBus target block
`include "sab_defines.vh"
`default_nettype none
module tb;
    timeunit 1ns / 100ps;
    logic        mclk = 1'b0, rst_n = 1'b0, clk_en;
    logic        enable_in, vdd_ok, vref_ok;
    logic [1:0]  strap0, strap1, strap2;
    logic [15:0] fault_in;
    logic [6:0]  dev = 7'h00;
    int          err_count = 0, checks = 0;
    wire         scl, sda, host_scl, host_sda_low, scl_o, scl_oe_n, sda_o, sda_oe_n;
    wire         alert_oe_n, addr_valid_q;
    wire  [6:0]  dev_addr_q;
    wire  [15:0] alert_mask_q, auto_mask_q;
    assign scl = host_scl & (scl_oe_n | scl_o);
    assign sda = !host_sda_low & (sda_oe_n | sda_o);
    always #5 mclk = !mclk;
    sab_host_model u_sab_host_model (.scl(host_scl), .sda_low(host_sda_low), .sda(sda));
    sab_smbus_target #(.TIMEOUT_CYC(22'd300)) u_sab_smbus_target (
        .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .scl_i(scl), .scl_o(scl_o),
        .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .alert_o(), .alert_oe_n(alert_oe_n), .strap_pin_0(strap0),
        .strap_pin_1(strap1), .strap_pin_2(strap2), .enable_in(enable_in), .vdd_ok(vdd_ok),
        .vref_ok(vref_ok), .fault_in(fault_in), .dev_addr_q(dev_addr_q),
        .addr_valid_q(addr_valid_q), .alert_mask_q(alert_mask_q), .auto_mask_q(auto_mask_q));
    task automatic close_out();
        $display("counts: checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    function automatic logic [6:0] exp_addr(input int i);
        if (i < 8) return 7'h40 + 7'(i);
        if (i < 16) return 7'h10 + 7'(i - 8);
        return 7'h50 + 7'(i - 16);
    endfunction
    // Address, command, n bytes low first, optional word read after repeated start
    task automatic txn(input logic [6:0] a, input logic [7:0] c, input logic [15:0] w,
                       input int n, input logic rd, output logic [15:0] q);
        logic [7:0] b;
        logic       k;
        u_sab_host_model.cond_c(1'b0);
        u_sab_host_model.byte_x({a, 1'b0}, 1'b1, b, k);
        cmp("addr ack", {15'h0, a != dev}, {15'h0, k});
        if (!k) begin
            u_sab_host_model.byte_x(c, 1'b1, b, k);
            for (int i = 0; i < n; i++) u_sab_host_model.byte_x(w[8*i +: 8], 1'b1, b, k);
            if (rd) begin
                u_sab_host_model.cond_c(1'b0);
                u_sab_host_model.byte_x({a, 1'b1}, 1'b1, b, k);
                u_sab_host_model.byte_x(8'hff, 1'b0, q[7:0], k);
                u_sab_host_model.byte_x(8'hff, 1'b1, q[15:8], k);
            end
        end
        u_sab_host_model.cond_c(1'b1);
        cyc(4);
    endtask
    task automatic ara(input logic ek);
        logic [7:0] b;
        logic       k;
        u_sab_host_model.cond_c(1'b0);
        u_sab_host_model.byte_x({`SAB_ARA_ADDR, 1'b1}, 1'b1, b, k);
        cmp("ara ack", {15'h0, ek}, {15'h0, k});
        if (!k) u_sab_host_model.byte_x(8'hff, 1'b1, b, k);
        if (!k) cmp("ara byte", {8'h0, dev, 1'b0}, {8'h0, b});
        u_sab_host_model.cond_c(1'b1);
        cyc(4);
    endtask
    initial begin
        logic [15:0] q;
        int          t;
        {clk_en, enable_in, vdd_ok, vref_ok} <= 4'h8;
        {strap2, strap1, strap0, fault_in} <= 22'h000000;
        cyc(6);
        rst_n <= 1'b1;
        enable_in <= 1'b1;
        vdd_ok <= 1'b1;
        cyc(20);
        cmp("valid no vref", 16'h0, {15'h0, addr_valid_q});
        cmp("mask reset", `SAB_MASK_RST, alert_mask_q);
        cmp("auto reset", 16'h0, auto_mask_q);
        cmp("oe reset", 16'h7, {13'h0, scl_oe_n, sda_oe_n, alert_oe_n});
        for (int i = 0; i < 27; i++) begin
            enable_in <= 1'b0;
            vref_ok <= 1'b1;
            cyc(8);
            {strap2, strap1, strap0} <= {2'(i / 9), 2'(i / 3 % 3), i == 0 ? 2'h3 : 2'(i % 3)};
            cyc(8);
            enable_in <= 1'b1;
            for (t = 0; t < 20 && addr_valid_q !== 1'b1; t++) @(posedge mclk);
            if (t == 20) begin
                cmp("strap latch", 16'h1, {15'h0, addr_valid_q});
                close_out();
            end
            cmp("strap addr", {9'h0, exp_addr(i)}, {9'h0, dev_addr_q});
        end
        dev = exp_addr(26);
        {strap2, strap1, strap0} <= 6'h00;
        cyc(10);
        cmp("addr kept", {9'h0, dev}, {9'h0, dev_addr_q});
        txn(7'h40, 8'h00, 16'h0, 0, 1'b0, q);
        $display("test strap decode done");
        txn(dev, `SAB_CMD_ALERT_MASK, 16'h8001, 2, 1'b0, q);
        cmp("mask write", 16'h8001, alert_mask_q);
        txn(dev, `SAB_CMD_ALERT_MASK, 16'h00ff, 1, 1'b0, q);
        cmp("mask lone byte", 16'h8001, alert_mask_q);
        txn(dev, `SAB_CMD_ALERT_MASK, 16'h0, 0, 1'b1, q);
        cmp("mask read", 16'h8001, q);
        txn(dev, 8'h20, 16'h0, 0, 1'b1, q);
        cmp("unmapped read", {2{`SAB_IDLE_BYTE}}, q);
        fault_in <= 16'h0001;
        cyc(3);
        cmp("alert masked", 16'h1, {15'h0, alert_oe_n});
        fault_in <= 16'h0012;
        cyc(3);
        cmp("alert on", 16'h0, {15'h0, alert_oe_n});
        $display("test mask done");
        ara(1'b0);
        cmp("auto mask", 16'h0012, auto_mask_q);
        cmp("alert released", 16'h1, {15'h0, alert_oe_n});
        ara(1'b1);
        fault_in <= 16'h0052;
        cyc(3);
        cmp("new fault", 16'h0, {15'h0, alert_oe_n});
        fault_in <= 16'h0012;
        cyc(3);
        cmp("no re-alert", 16'h1, {15'h0, alert_oe_n});
        txn(dev, `SAB_CMD_CLEAR_FAULT, 16'h0, 0, 1'b0, q);
        cmp("auto cleared", 16'h0, auto_mask_q);
        cmp("alert again", 16'h0, {15'h0, alert_oe_n});
        clk_en <= 1'b0;
        fault_in <= 16'h0000;
        cyc(5);
        cmp("frozen alert", 16'h0, {15'h0, alert_oe_n});
        clk_en <= 1'b1;
        cyc(3);
        cmp("alert off", 16'h1, {15'h0, alert_oe_n});
        $display("test alert done");
        u_sab_host_model.cond_c(1'b0);
        for (int i = 7; i >= 0; i--) u_sab_host_model.bit_x(i == 0 ? 1'b0 : dev[i - 1], q[0]);
        u_sab_host_model.low_c();
        cyc(250);
        cmp("ack held", 16'h0, {15'h0, sda_oe_n});
        cyc(70);
        cmp("timeout release", 16'h1, {15'h0, sda_oe_n});
        u_sab_host_model.cond_c(1'b1);
        txn(dev, `SAB_CMD_ALERT_MASK, 16'h0, 0, 1'b0, q);
        vdd_ok <= 1'b0;
        cyc(8);
        cmp("valid dropped", 16'h0, {15'h0, addr_valid_q});
        $display("test timeout and rails done");
        close_out();
    end
endmodule
`default_nettype wire

// ### verilog/sab_smbus_target.v
// SMBus target with strap address decode, clock-low timeout and masked alert
// Function
// - Each of the three strap pins is read as open, low or high, giving 27 addresses.
// - The 7-bit address comes from index 9*p2+3*p1+p0 mapped onto 40h, 10h and 50h groups.
// - Straps are latched only once enable and both supply rails are good.
// - A clock-low interval beyond 25 ms drops bus communication back to idle.
// - The target never stretches the clock, so its cumulative stretch stays at zero.
// - The alert output is gated by the alert mask register at D8h and by an automatic mask.
// - An alert response read returns this address only while alert is asserted, with arbitration.
// - A won alert response read sets the automatic mask for every fault active at that read.
// - Fault inputs are not latched, and only the clear fault command clears the automatic mask.
`include "sab_defines.vh"
`default_nettype none
module sab_smbus_target #(
    parameter [`SAB_TIMEOUT_W-1:0] TIMEOUT_CYC = `SAB_TIMEOUT_CYC
) (
    input  wire        mclk,
    input  wire        rst_n,
    input  wire        clk_en,
    input  wire        scl_i,
    output wire        scl_o,
    output wire        scl_oe_n,
    input  wire        sda_i,
    output wire        sda_o,
    output wire        sda_oe_n,
    output wire        alert_o,
    output wire        alert_oe_n,
    input  wire [1:0]  strap_pin_0,
    input  wire [1:0]  strap_pin_1,
    input  wire [1:0]  strap_pin_2,
    input  wire        enable_in,
    input  wire        vdd_ok,
    input  wire        vref_ok,
    input  wire [15:0] fault_in,
    output reg  [6:0]  dev_addr_q,
    output reg         addr_valid_q,
    output reg  [15:0] alert_mask_q,
    output reg  [15:0] auto_mask_q
);
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_ADDR  = 3'h1;
    localparam [2:0] ST_ACK   = 3'h2;
    localparam [2:0] ST_RX    = 3'h3;
    localparam [2:0] ST_TX    = 3'h4;
    localparam [2:0] ST_TXREL = 3'h5;
    localparam [2:0] ST_TXACK = 3'h6;
    localparam [10:0] SYNC_RST = 11'h600;
    wire [10:0] raw_in = {scl_i, sda_i, enable_in, vdd_ok, vref_ok,
                          strap_pin_2, strap_pin_1, strap_pin_0};
    reg  [10:0] s1_q;
    reg  [10:0] s2_q;
    reg  [10:0] s3_q;
    reg  [10:0] filt_q;
    genvar gi;
    generate
        for (gi = 0; gi < 11; gi = gi + 1) begin : g_sync
            always @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_q[gi]   <= SYNC_RST[gi];
                    s2_q[gi]   <= SYNC_RST[gi];
                    s3_q[gi]   <= SYNC_RST[gi];
                    filt_q[gi] <= SYNC_RST[gi];
                end else if (clk_en) begin
                    s1_q[gi] <= raw_in[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi]) begin
                        filt_q[gi] <= s3_q[gi];
                    end
                end
            end
        end
    endgenerate
    wire scl_f   = filt_q[10];
    wire sda_f   = filt_q[9];
    wire ready_f = filt_q[8] & filt_q[7] & filt_q[6];
    function [1:0] lvl;
        input [1:0] code;
        begin
            lvl = (code == `SAB_STRAP_LOW)  ? 2'h1 :
                  (code == `SAB_STRAP_HIGH) ? 2'h2 : 2'h0;
        end
    endfunction
    wire [4:0] p0 = {3'h0, lvl(filt_q[1:0])};
    wire [4:0] p1 = {3'h0, lvl(filt_q[3:2])};
    wire [4:0] p2 = {3'h0, lvl(filt_q[5:4])};
    wire [4:0] strap_idx = (p2 * 5'h09) + (p1 * 5'h03) + p0;
    wire [6:0] idx7 = {2'h0, strap_idx};
    wire [6:0] strap_addr =
        (strap_idx < `SAB_GRP1_IDX) ? `SAB_GRP0_BASE + idx7 :
        (strap_idx < `SAB_GRP2_IDX) ? `SAB_GRP1_BASE + idx7 - {2'h0, `SAB_GRP1_IDX} :
                                      `SAB_GRP2_BASE + idx7 - {2'h0, `SAB_GRP2_IDX};
    reg        scl_p_q;
    reg        sda_p_q;
    reg  [2:0] st_q;
    reg  [2:0] nxt_q;
    reg  [2:0] bit_q;
    reg  [7:0] sh_q;
    reg  [7:0] cmd_q;
    reg  [1:0] rx_idx_q;
    reg  [1:0] tx_idx_q;
    reg  [7:0] lo_byte_q;
    reg        ara_q;
    reg        sda_drv_q;
    reg        ready_q;
    reg        alert_q;
    reg [15:0] fsnap_q;
    reg [`SAB_TIMEOUT_W-1:0] low_cnt_q;
    wire scl_rise = scl_f & ~scl_p_q;
    wire scl_fall = ~scl_f & scl_p_q;
    wire bus_start = scl_f & scl_p_q & sda_p_q & ~sda_f;
    wire bus_stop  = scl_f & scl_p_q & ~sda_p_q & sda_f;
    wire timeout   = (low_cnt_q >= TIMEOUT_CYC);
    wire [7:0] rx_byte = {sh_q[6:0], sda_f};
    wire alert_d = |(fault_in & ~alert_mask_q & ~auto_mask_q);
    // Byte to send for the next read byte
    function [7:0] tx_byte;
        input [7:0] cmd;
        input [1:0] idx;
        input [15:0] mask;
        begin
            tx_byte = (cmd != `SAB_CMD_ALERT_MASK || idx[1]) ? `SAB_IDLE_BYTE :
                      (idx[0] ? mask[15:8] : mask[7:0]);
        end
    endfunction
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_q <= {`SAB_TIMEOUT_W{1'b0}};
        end else if (clk_en) begin
            if (scl_f) begin
                low_cnt_q <= {`SAB_TIMEOUT_W{1'b0}};
            end else if (!timeout) begin
                low_cnt_q <= low_cnt_q + 1'b1;
            end
        end
    end
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ready_q      <= 1'b0;
            dev_addr_q   <= 7'h00;
            addr_valid_q <= 1'b0;
            alert_q      <= 1'b0;
        end else if (clk_en) begin
            ready_q <= ready_f;
            alert_q <= alert_d;
            if (!ready_f) begin
                addr_valid_q <= 1'b0;
            end else if (!ready_q) begin
                dev_addr_q   <= strap_addr;
                addr_valid_q <= 1'b1;
            end
        end
    end
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            scl_p_q      <= 1'b1;
            sda_p_q      <= 1'b1;
            st_q         <= ST_IDLE;
            nxt_q        <= ST_IDLE;
            bit_q        <= 3'h0;
            sh_q         <= 8'h00;
            cmd_q        <= 8'h00;
            rx_idx_q     <= 2'h0;
            tx_idx_q     <= 2'h0;
            lo_byte_q    <= 8'h00;
            ara_q        <= 1'b0;
            sda_drv_q    <= 1'b0;
            fsnap_q      <= 16'h0000;
            alert_mask_q <= `SAB_MASK_RST;
            auto_mask_q  <= 16'h0000;
        end else if (clk_en) begin
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
            if (timeout || bus_stop) begin
                st_q      <= ST_IDLE;
                sda_drv_q <= 1'b0;
            end else if (bus_start) begin
                st_q      <= ST_ADDR;
                bit_q     <= 3'h0;
                sda_drv_q <= 1'b0;
            end else begin
                case (st_q)
                    ST_ADDR: begin
                        if (scl_rise) begin
                            sh_q  <= rx_byte;
                            bit_q <= bit_q + 1'b1;
                            if (bit_q == 3'h7) begin
                                ara_q    <= 1'b0;
                                tx_idx_q <= 2'h0;
                                rx_idx_q <= 2'h0;
                                if (addr_valid_q && rx_byte[7:1] == dev_addr_q) begin
                                    st_q  <= ST_ACK;
                                    nxt_q <= rx_byte[0] ? ST_TX : ST_RX;
                                    sh_q  <= tx_byte(cmd_q, 2'h0, alert_mask_q);
                                end else if (rx_byte == {`SAB_ARA_ADDR, 1'b1} &&
                                             alert_q && addr_valid_q) begin
                                    st_q    <= ST_ACK;
                                    nxt_q   <= ST_TX;
                                    ara_q   <= 1'b1;
                                    fsnap_q <= fault_in;
                                    sh_q    <= {dev_addr_q, 1'b0};
                                end else begin
                                    st_q <= ST_IDLE;
                                end
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            if (!sda_drv_q) begin
                                sda_drv_q <= 1'b1;
                            end else begin
                                st_q      <= nxt_q;
                                bit_q     <= 3'h0;
                                sda_drv_q <= (nxt_q == ST_TX) ? ~sh_q[7] : 1'b0;
                            end
                        end
                    end
                    ST_RX: begin
                        if (scl_rise) begin
                            sh_q  <= rx_byte;
                            bit_q <= bit_q + 1'b1;
                            if (bit_q == 3'h7) begin
                                st_q  <= ST_ACK;
                                nxt_q <= ST_RX;
                                if (rx_idx_q == 2'h0) begin
                                    cmd_q    <= rx_byte;
                                    rx_idx_q <= 2'h1;
                                    if (rx_byte == `SAB_CMD_CLEAR_FAULT) begin
                                        auto_mask_q <= 16'h0000;
                                    end
                                end else if (cmd_q == `SAB_CMD_ALERT_MASK) begin
                                    if (rx_idx_q == 2'h1) begin
                                        lo_byte_q <= rx_byte;
                                        rx_idx_q  <= 2'h2;
                                    end else if (rx_idx_q == 2'h2) begin
                                        alert_mask_q <= {rx_byte, lo_byte_q};
                                        rx_idx_q     <= 2'h3;
                                    end
                                end
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            sda_drv_q <= ~sh_q[7];
                        end else if (scl_rise) begin
                            sh_q  <= {sh_q[6:0], 1'b0};
                            bit_q <= bit_q + 1'b1;
                            if (ara_q && !sda_drv_q && !sda_f) begin
                                st_q <= ST_IDLE;
                            end else if (bit_q == 3'h7) begin
                                st_q <= ST_TXREL;
                                if (ara_q) begin
                                    auto_mask_q <= auto_mask_q | fsnap_q;
                                end
                            end
                        end
                    end
                    ST_TXREL: begin
                        if (scl_fall) begin
                            sda_drv_q <= 1'b0;
                            st_q      <= ST_TXACK;
                        end
                    end
                    ST_TXACK: begin
                        if (scl_rise) begin
                            bit_q <= 3'h0;
                            if (!sda_f && !ara_q) begin
                                st_q     <= ST_TX;
                                tx_idx_q <= tx_idx_q + 1'b1;
                                sh_q     <= tx_byte(cmd_q, tx_idx_q + 1'b1, alert_mask_q);
                            end else begin
                                st_q <= ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        st_q      <= ST_IDLE;
                        sda_drv_q <= 1'b0;
                    end
                endcase
            end
        end
    end
    assign scl_o      = 1'b0;
    assign scl_oe_n   = 1'b1;
    assign sda_o      = 1'b0;
    assign sda_oe_n   = ~sda_drv_q;
    assign alert_o    = 1'b0;
    assign alert_oe_n = ~alert_q;
endmodule
`default_nettype wire
